// *** verilog/dct_top.sv ***
// Two counter/timers with control, mode and clock-select registers on AXI4-Lite.
//
// Added by the designer: the AXI4-Lite register port.
`include "dct_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dct_top #(
  parameter int AW = 12
) (
  // Clock, reset and clock enable.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  // AXI4-Lite write channels.
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Asynchronous pins.
  input  wire logic          zero_count_pin,
  input  wire logic          one_count_pin,
  input  wire logic          gating_irq_input,
  input  wire logic          irq_b_input,
  input  wire logic          ext_clock,
  // Vectoring acknowledges from the interrupt logic.
  input  wire logic          ack_zero,
  input  wire logic          ack_one,
  input  wire logic          ack_a,
  input  wire logic          ack_b,
  // Third timer configuration.
  input  wire logic          third_split,
  input  wire logic          third_ext_clock_sel,
  // Requests and ticks.
  output logic               zero_irq_req,
  output logic               one_irq_req,
  output logic               ext_a_irq_req,
  output logic               ext_b_irq_req,
  output logic               one_baud_tick,
  output logic               third_low_tick,
  output logic               third_high_tick
);

  ////////////////////////////////////////////////////////////
  // Elaboration check and state.

  // The register index needs address bits nine to two.
  if (AW < 12 || AW > 32) begin : g_bad_aw
    $error("dct_top: AW must lie between 12 and 32.");
  end

  dct_pkg::dct_state_t st_r;
  dct_pkg::dct_state_t st_nxt;

  logic ovf0_c;
  logic ovf1_c;
  logic ovfh_c;
  logic split_c;
  logic act_a_c;
  logic wr_c;

  // One counting step: overflow bit, next high byte, next low byte.
  function automatic logic [16:0] dct_step(
    input logic [1:0] m,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [12:0] v13;
    logic [15:0] v16;
    logic [7:0]  v8;
    v13 = {hi, lo[4:0]} + 13'h0001;
    v16 = {hi, lo} + 16'h0001;
    v8 = lo + 8'h01;
    dct_step = 17'h00000;
    unique case (m)
      dct_pkg::DCT_M13: dct_step = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
      dct_pkg::DCT_M16: dct_step = {&{hi, lo}, v16};
      dct_pkg::DCT_M8R: dct_step = {&lo, hi, (&lo) ? hi : v8};
      dct_pkg::DCT_MSPL: dct_step = {&lo, hi, v8};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  // Next-state logic.

  // Builds the whole next state from the current one.
  always_comb begin
    logic [16:0] s;
    logic [4:0]  fall;
    logic        p12;
    logic        p4;
    logic        p48;
    logic        px8;
    logic        xr;
    logic        pre;
    logic        tk0;
    logic        tk1;
    logic        src0;
    logic        src1;
    logic        en0;
    logic        en1;
    logic        act_b;
    logic        edge_a;
    logic        edge_b;
    logic        t2src;
    logic        hit;
    logic        wc;
    logic        rok;
    logic [7:0]  rb;
    logic [7:0]  wd;
    logic [7:0]  ridx;
    s = 17'h00000;
    st_nxt = st_r;
    ovf0_c = 1'b0;
    ovf1_c = 1'b0;
    ovfh_c = 1'b0;

    st_nxt.s1 = {ext_clock, irq_b_input, gating_irq_input, one_count_pin, zero_count_pin};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    fall = st_r.s3 & ~st_r.s2;
    xr = st_r.s2[`DCT_PIN_XCLK] & ~st_r.s3[`DCT_PIN_XCLK];

    p12 = st_r.div12 == `DCT_DIV12_END;
    p4 = st_r.div4 == `DCT_DIV4_END;
    p48 = st_r.div48 == `DCT_DIV48_END;
    px8 = xr && st_r.ext8 == `DCT_EXT8_END;
    st_nxt.div12 = p12 ? 4'h0 : st_r.div12 + 4'h1;
    st_nxt.div4 = st_r.div4 + 2'h1;
    st_nxt.div48 = p48 ? 6'h00 : st_r.div48 + 6'h01;
    st_nxt.ext8 = st_r.ext8 + {2'h0, xr};
    unique case (st_r.timer_clock_select[1:0])
      2'h0: pre = p12;
      2'h1: pre = p4;
      2'h2: pre = p48;
      2'h3: pre = px8;
    endcase

    tk0 = st_r.timer_clock_select[`DCT_CLK_T0M] | pre;
    tk1 = st_r.timer_clock_select[`DCT_CLK_T1M] | pre;
    split_c = st_r.timer_mode_select[1:0] == dct_pkg::DCT_MSPL;

    act_a_c = st_r.s2[`DCT_PIN_IRQA] ~^ st_r.icfg[`DCT_IRQ_POLA];
    act_b = st_r.s2[`DCT_PIN_IRQB] ~^ st_r.icfg[`DCT_IRQ_POLB];
    edge_a = act_a_c & ~(st_r.s3[`DCT_PIN_IRQA] ~^ st_r.icfg[`DCT_IRQ_POLA]);
    edge_b = act_b & ~(st_r.s3[`DCT_PIN_IRQB] ~^ st_r.icfg[`DCT_IRQ_POLB]);

    en0 = st_r.timer_control_status[`DCT_CTL_TR0] & (~st_r.timer_mode_select[`DCT_MOD_ZERO_GATING_BIT] | act_a_c);
    en1 = (split_c | st_r.timer_control_status[`DCT_CTL_TR1]) & (st_r.timer_mode_select[5:4] != dct_pkg::DCT_MSPL) &
          (~st_r.timer_mode_select[`DCT_MOD_ONE_GATING_BIT] | act_b);

    src0 = st_r.timer_mode_select[`DCT_MOD_CT0] ? fall[`DCT_PIN_T0] : tk0;
    src1 = (st_r.timer_mode_select[`DCT_MOD_CT1] & ~split_c) ? fall[`DCT_PIN_T1] : tk1;

    if (en0 && src0) begin
      s = dct_step(st_r.timer_mode_select[1:0], st_r.th0, st_r.tl0);
      st_nxt.tl0 = s[7:0];
      if (!split_c) begin
        st_nxt.th0 = s[15:8];
      end
      ovf0_c = s[16];
    end

    // high byte runs from other run bit
    if (split_c && st_r.timer_control_status[`DCT_CTL_TR1] && tk0) begin
      s = dct_step(dct_pkg::DCT_MSPL, 8'h00, st_r.th0);
      st_nxt.th0 = s[7:0];
      ovfh_c = s[16];
    end

    // Timer one advances in modes zero to two.
    if (en1 && src1) begin
      s = dct_step(st_r.timer_mode_select[5:4], st_r.th1, st_r.tl1);
      st_nxt.tl1 = s[7:0];
      st_nxt.th1 = s[15:8];
      ovf1_c = s[16];
    end
    st_nxt.baud = ovf1_c;

    // low byte clock, high byte only in split
    t2src = third_ext_clock_sel ? px8 : p12;
    st_nxt.t2lo = st_r.timer_clock_select[`DCT_CLK_THIRD_LOW_CLOCK_SEL] | t2src;
    st_nxt.t2hi = third_split ? (st_r.timer_clock_select[`DCT_CLK_THIRD_HIGH_CLOCK_SEL] | t2src) : st_nxt.t2lo;

    ////////////////////////////////////////////////////////////
    // Write channels.

    // Address and data are taken independently.
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[9:2];
      st_nxt.aw_ok = ~|s_axi_awaddr[AW-1:10];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_byte = s_axi_wdata[7:0];
      st_nxt.w_lane = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Performs the write once both halves are held.
    wd = st_r.w_byte;
    hit = 1'b0;
    wr_c = 1'b0;
    wc = 1'b0;
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      hit = st_r.aw_ok;
      wr_c = st_r.aw_ok & st_r.w_lane;
      case (st_r.aw_idx)
        `DCT_IDX_CTRL: wc = wr_c;
        `DCT_IDX_MODE: if (wr_c) st_nxt.timer_mode_select = wd;
        `DCT_IDX_TL0: if (wr_c) st_nxt.tl0 = wd;
        `DCT_IDX_TL1: if (wr_c) st_nxt.tl1 = wd;
        `DCT_IDX_TH0: if (wr_c) st_nxt.th0 = wd;
        `DCT_IDX_TH1: if (wr_c) st_nxt.th1 = wd;
        `DCT_IDX_CLK: if (wr_c) st_nxt.timer_clock_select = wd & `DCT_CLK_MASK;
        `DCT_IDX_IRQ: if (wr_c) st_nxt.icfg = wd & `DCT_IRQ_MASK;
        default: begin
          hit = 1'b0;
          wr_c = 1'b0;
        end
      endcase
      st_nxt.bresp = hit ? `DCT_RESP_OKAY : `DCT_RESP_DECERR;
    end
    if (wc) begin
      st_nxt.timer_control_status = wd;
    end

    st_nxt.timer_control_status[`DCT_CTL_TF0] = ovf0_c |
      (wc ? wd[`DCT_CTL_TF0] : st_r.timer_control_status[`DCT_CTL_TF0] & ~ack_zero);
    st_nxt.timer_control_status[`DCT_CTL_TF1] = ovfh_c | (ovf1_c & ~split_c) |
      (wc ? wd[`DCT_CTL_TF1] : st_r.timer_control_status[`DCT_CTL_TF1] & ~ack_one);

    if (st_r.timer_control_status[`DCT_CTL_ITA]) begin
      st_nxt.timer_control_status[`DCT_CTL_IEA] = edge_a |
        (wc ? wd[`DCT_CTL_IEA] : st_r.timer_control_status[`DCT_CTL_IEA] & ~ack_a);
    end else begin
      st_nxt.timer_control_status[`DCT_CTL_IEA] = act_a_c;
    end
    if (st_r.timer_control_status[`DCT_CTL_ITB]) begin
      st_nxt.timer_control_status[`DCT_CTL_IEB] = edge_b |
        (wc ? wd[`DCT_CTL_IEB] : st_r.timer_control_status[`DCT_CTL_IEB] & ~ack_b);
    end else begin
      st_nxt.timer_control_status[`DCT_CTL_IEB] = act_b;
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    ////////////////////////////////////////////////////////////
    // Read channels.

    // Decodes the read address into a byte.
    ridx = s_axi_araddr[9:2];
    rok = ~|s_axi_araddr[AW-1:10];
    rb = 8'h00;
    case (ridx)
      `DCT_IDX_CTRL: rb = st_r.timer_control_status;
      `DCT_IDX_MODE: rb = st_r.timer_mode_select;
      `DCT_IDX_TL0: rb = st_r.tl0;
      `DCT_IDX_TL1: rb = st_r.tl1;
      `DCT_IDX_TH0: rb = st_r.th0;
      `DCT_IDX_TH1: rb = st_r.th1;
      `DCT_IDX_CLK: rb = st_r.timer_clock_select;
      `DCT_IDX_IRQ: rb = st_r.icfg;
      default: rok = 1'b0;
    endcase
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rok ? rb : 8'h00;
      st_nxt.rresp = rok ? `DCT_RESP_OKAY : `DCT_RESP_DECERR;
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  // Registers the state; the clock enable freezes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs.

  // Every output is a field of the state register.
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = {24'h000000, st_r.rdata};
  assign s_axi_rresp = st_r.rresp;
  assign zero_irq_req = st_r.timer_control_status[`DCT_CTL_TF0];
  assign one_irq_req = st_r.timer_control_status[`DCT_CTL_TF1];
  assign ext_a_irq_req = st_r.timer_control_status[`DCT_CTL_IEA];
  assign ext_b_irq_req = st_r.timer_control_status[`DCT_CTL_IEB];
  assign one_baud_tick = st_r.baud;
  assign third_low_tick = st_r.t2lo;
  assign third_high_tick = st_r.t2hi;

  ////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Input inactive, then active in edge mode.
  sequence seq_a_quiet;
    ce && !act_a_c;
  endsequence
  sequence seq_a_rise;
    ce && act_a_c && st_r.timer_control_status[`DCT_CTL_ITA];
  endsequence

  AST_CLK_RSVD_ZERO:
    assert property (st_r.timer_clock_select[7:6] == 2'h0)
      else $error("Reserved clock-select bits not zero.");
  AST_TF0_SETS:
    assert property (ce && ovf0_c |=> st_r.timer_control_status[`DCT_CTL_TF0])
      else $error("Timer zero overflow did not set its flag.");
  AST_SPLIT_NO_TF1:
    assert property (ce && split_c && !ovfh_c && !wr_c && !st_r.timer_control_status[`DCT_CTL_TF1]
                     |=> !st_r.timer_control_status[`DCT_CTL_TF1])
      else $error("Timer one flag set in split mode.");
  AST_TH0_FROM_TR1:
    assert property (ce && split_c && !st_r.timer_control_status[`DCT_CTL_TR1] && !wr_c
                     |=> $stable(st_r.th0))
      else $error("Split high byte moved without run bit.");
  AST_ONE_STOP_M3:
    assert property (ce && split_c && st_r.timer_mode_select[5:4] == 2'h3 && !wr_c
                     |=> $stable({st_r.th1, st_r.tl1}))
      else $error("Timer one ran in mode three.");
  AST_RELOAD:
    assert property (ce && st_r.timer_mode_select[1:0] == 2'h2 && ovf0_c && !wr_c
                     |=> st_r.tl0 == $past(st_r.th0) && $stable(st_r.th0))
      else $error("Reload mode did not reload low byte.");
  AST_GATE_OFF:
    assert property (ce && st_r.timer_mode_select[`DCT_MOD_ZERO_GATING_BIT] && !act_a_c && !split_c && !wr_c
                     |=> $stable({st_r.th0, st_r.tl0}))
      else $error("Gated timer zero counted.");
  AST_EDGE_FLAG:
    assert property (seq_a_quiet ##1 seq_a_rise |=> st_r.timer_control_status[`DCT_CTL_IEA])
      else $error("Edge did not set external flag.");
  AST_LEVEL_FLAG:
    assert property (ce && !st_r.timer_control_status[`DCT_CTL_ITA]
                     |=> st_r.timer_control_status[`DCT_CTL_IEA] == $past(act_a_c))
      else $error("Level flag does not follow input.");
  AST_TF1_SPLIT:
    assert property (ce && split_c && ovfh_c |=> one_irq_req)
      else $error("Split high byte overflow lost.");

endmodule

`default_nettype wire

// *** verilog/dct_params.svh ***
// Register map, field positions and divider counts of the dual timer block.
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH
`define DCT_IDX_CTRL 8'h88
`define DCT_IDX_MODE 8'h89
`define DCT_IDX_TL0 8'h8A
`define DCT_IDX_TL1 8'h8B
`define DCT_IDX_TH0 8'h8C
`define DCT_IDX_TH1 8'h8D
`define DCT_IDX_CLK 8'h8E
`define DCT_IDX_IRQ 8'h90
`define DCT_RST_BYTE 8'h00
`define DCT_CTL_TF1 7
`define DCT_CTL_TR1 6
`define DCT_CTL_TF0 5
`define DCT_CTL_TR0 4
`define DCT_CTL_IEB 3
`define DCT_CTL_ITB 2
`define DCT_CTL_IEA 1
`define DCT_CTL_ITA 0
`define DCT_MOD_ONE_GATING_BIT 7
`define DCT_MOD_CT1 6
`define DCT_MOD_ZERO_GATING_BIT 3
`define DCT_MOD_CT0 2
`define DCT_CLK_THIRD_HIGH_CLOCK_SEL 5
`define DCT_CLK_THIRD_LOW_CLOCK_SEL 4
`define DCT_CLK_T1M 3
`define DCT_CLK_T0M 2
`define DCT_CLK_MASK 8'h3F
`define DCT_IRQ_POLA 0
`define DCT_IRQ_POLB 1
`define DCT_IRQ_MASK 8'h03
`define DCT_DIV12_END 4'hB
`define DCT_DIV4_END 2'h3
`define DCT_DIV48_END 6'h2F
`define DCT_EXT8_END 3'h7
`define DCT_PIN_T0 0
`define DCT_PIN_T1 1
`define DCT_PIN_IRQA 2
`define DCT_PIN_IRQB 3
`define DCT_PIN_XCLK 4
`define DCT_RESP_OKAY 2'h0
`define DCT_RESP_DECERR 2'h3
`endif

// *** verilog/dct_pkg.sv ***
// Types shared by the dual timer design.
`default_nettype none
package dct_pkg;
  typedef enum logic [1:0] {
    DCT_M13  = 2'h0,
    DCT_M16  = 2'h1,
    DCT_M8R  = 2'h2,
    DCT_MSPL = 2'h3
  } dct_mode_t;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [3:0] div12;
    logic [1:0] div4;
    logic [5:0] div48;
    logic [2:0] ext8;
    logic [7:0] timer_control_status;
    logic [7:0] timer_mode_select;
    logic [7:0] timer_clock_select;
    logic [7:0] icfg;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic       baud;
    logic       t2lo;
    logic       t2hi;
    logic       aw_held;
    logic       aw_ok;
    logic [7:0] aw_idx;
    logic       w_held;
    logic       w_lane;
    logic [7:0] w_byte;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } dct_state_t;
endpackage
`default_nettype wire

// *** verification/dct_pin_model.sv ***
// Behavioural model of the count pins, gate pins and external clock.
`timescale 1ns/1ps
`default_nettype none

module dct_pin_model (
  // Clock.
  input  wire logic       aclk,
  // Commands from the bench.
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [3:0] n,
  input  wire logic       lvl_a,
  input  wire logic       lvl_b,
  input  wire logic       ext_en,
  // Pins.
  output logic            busy,
  output logic [1:0]      cnt_pin,
  output logic            gate_a,
  output logic            gate_b,
  output logic            ext_clock
);
  // The gate pins follow the commanded levels.
  assign gate_a = lvl_a;
  assign gate_b = lvl_b;

  initial begin
    busy = 1'b0;
    cnt_pin = 2'b11;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < n; i++) begin
          cnt_pin[sel] <= 1'b0;
          repeat (3) @(posedge aclk);
          cnt_pin[sel] <= 1'b1;
          repeat (3) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end

  // The external oscillator runs at 10 MHz only while enabled, else it rests low.
  initial begin
    ext_clock = 1'b0;
    #7;
    forever #50 ext_clock = ext_en & ~ext_clock;
  end
endmodule
`default_nettype wire

// *** verification/dct_top_tb.sv ***
// Self-checking bench for the dual counter/timer block.
`include "dct_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dct_top_tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, go, sel, ext_en, busy, split;
  logic        gate_a, gate_b, ext_clock, zreq, oreq, areq, breq, baud, tlo, thi, win, xsel;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  n, ack;
  logic [1:0]  bresp, rresp, resp, lvl, cnt_pin;
  int          failures, checks, cycles, n_baud, n_lo, n_hi;

  // Device under test and the pin model.
  dct_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .zero_count_pin(cnt_pin[0]), .one_count_pin(cnt_pin[1]), .gating_irq_input(gate_a),
    .irq_b_input(gate_b), .ext_clock(ext_clock),
    .ack_zero(ack[0]), .ack_one(ack[1]), .ack_a(ack[2]), .ack_b(ack[3]),
    .third_split(split), .third_ext_clock_sel(xsel),
    .zero_irq_req(zreq), .one_irq_req(oreq), .ext_a_irq_req(areq), .ext_b_irq_req(breq),
    .one_baud_tick(baud), .third_low_tick(tlo), .third_high_tick(thi)
  );
  dct_pin_model i_pins (
    .aclk(aclk), .go(go), .sel(sel), .n(n), .lvl_a(lvl[0]), .lvl_b(lvl[1]),
    .ext_en(ext_en), .busy(busy), .cnt_pin(cnt_pin), .gate_a(gate_a), .gate_b(gate_b),
    .ext_clock(ext_clock)
  );

  // The 25 MHz clock.
  always #20 aclk = ~aclk;

  // Tick counters and the guard against a hang.
  always @(posedge aclk) begin
    cycles++;
    n_baud += int'(baud === 1'b1);
    if (win === 1'b1) begin
      n_lo += int'(tlo === 1'b1);
      n_hi += int'(thi === 1'b1);
    end
    if (cycles == 20000) begin
      failures++;
      $display("CHECK FAILED %0t timeout", $time);
      end_of_test;
    end
  end

  ////////////////////////////////////////
  // Compare tasks, one for each kind of result.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %b", $time, m, got);
    end
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi, input string m);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("CHECK FAILED %0t %s count %0d", $time, m, got);
    end
  endtask

  // Bus tasks; each channel is released at the edge where it is taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string m);
    logic [7:0] d;
    rd(idx, d);
    chk_byte(d, exp, m);
  endtask

  // Pin helpers: an acknowledge pulse, a gate window and a burst of count edges.
  task automatic ack_pulse(input int i);
    @(posedge aclk);
    ack[i] <= 1'b1;
    @(posedge aclk);
    ack[i] <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic gate(input int i, input int c);
    @(posedge aclk);
    lvl[i] <= 1'b1;
    repeat (c) @(posedge aclk);
    lvl[i] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic pins(input logic s, input logic [3:0] k);
    @(posedge aclk);
    go <= 1'b1;
    sel <= s;
    n <= k;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy === 1'b1);
    repeat (6) @(posedge aclk);
  endtask

  ////////////////////////////////////////
  // Reset values, decode errors, reserved bits and the low byte.
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] idx [8] = '{`DCT_IDX_CTRL, `DCT_IDX_MODE, `DCT_IDX_TL0, `DCT_IDX_TL1,
                            `DCT_IDX_TH0, `DCT_IDX_TH1, `DCT_IDX_CLK, `DCT_IDX_IRQ};
    // Level-type external flags follow the low pins, which are active at reset polarity.
    foreach (idx[i]) rd_chk(idx[i], (i == 0) ? 8'h0A : `DCT_RST_BYTE, "reset value");
    rd(8'h8F, d);
    chk_byte({6'h0, resp}, {6'h0, `DCT_RESP_DECERR}, "read decode");
    wr(8'h8F, 8'h55);
    chk_byte({6'h0, resp}, {6'h0, `DCT_RESP_DECERR}, "write decode");
    wr(`DCT_IDX_CLK, 8'hFF);
    rd_chk(`DCT_IDX_CLK, 8'h3F, "clock select top bits");
    wr(`DCT_IDX_TL0, 8'hA5);
    rd_chk(`DCT_IDX_TL0, 8'hA5, "low byte");
    wr(`DCT_IDX_IRQ, 8'h03);
    $display("regs test done");
  endtask

  // Gated counting in the 16-bit, 13-bit and reload modes.
  task automatic t_modes;
    logic [7:0] t [3][6] = '{'{8'h01, 8'hFC, 8'hFF, 8'h06, 8'h02, 8'h00},
                             '{8'h00, 8'h1E, 8'hFF, 8'h03, 8'h01, 8'h00},
                             '{8'h02, 8'hFE, 8'hF0, 8'h03, 8'hF1, 8'hF0}};
    wr(`DCT_IDX_CLK, 8'h04);
    for (int i = 0; i < 3; i++) begin
      wr(`DCT_IDX_MODE, 8'h08 | t[i][0]);
      wr(`DCT_IDX_TL0, t[i][1]);
      wr(`DCT_IDX_TH0, t[i][2]);
      wr(`DCT_IDX_CTRL, 8'h10);
      repeat (8) @(posedge aclk);
      gate(0, t[i][3]);
      rd_chk(`DCT_IDX_TL0, t[i][4], "count low");
      rd_chk(`DCT_IDX_TH0, t[i][5], "count high");
      chk_bit(zreq, 1'b1, "overflow set");
      if (i == 0) ack_pulse(0);
      else wr(`DCT_IDX_CTRL, 8'h10);
      chk_bit(zreq, 1'b0, "overflow cleared");
    end
    wr(`DCT_IDX_CTRL, 8'h00);
    gate(0, 5);
    rd_chk(`DCT_IDX_TL0, 8'hF1, "run bit off");
    $display("modes test done");
  endtask

  // Prescaler settings, the last one from the external clock.
  task automatic t_prescale;
    logic [7:0] d;
    int         t [4][3] = '{'{96, 8, 8}, '{96, 24, 24}, '{96, 2, 2}, '{400, 19, 21}};
    wr(`DCT_IDX_MODE, 8'h09);
    for (int p = 0; p < 4; p++) begin
      ext_en <= (p == 3);
      wr(`DCT_IDX_CLK, 8'(p));
      wr(`DCT_IDX_TL0, 8'h00);
      wr(`DCT_IDX_CTRL, 8'h10);
      gate(0, t[p][0]);
      rd(`DCT_IDX_TL0, d);
      chk_cnt(d, t[p][1], t[p][2], "prescaled count");
    end
    ext_en <= 1'b0;
    $display("prescale test done");
  endtask

  // Counter function on both count pins with the clock selects set.
  task automatic t_count;
    wr(`DCT_IDX_CLK, 8'h0C);
    wr(`DCT_IDX_MODE, 8'h55);
    wr(`DCT_IDX_TL0, 8'h00);
    wr(`DCT_IDX_TL1, 8'h00);
    wr(`DCT_IDX_CTRL, 8'h50);
    pins(1'b0, 4'h5);
    pins(1'b1, 4'h3);
    rd_chk(`DCT_IDX_TL0, 8'h05, "pin zero edges");
    rd_chk(`DCT_IDX_TL1, 8'h03, "pin one edges");
    $display("count test done");
  endtask

  // Split mode with timer one running, then stopped by its mode field.
  task automatic t_split;
    wr(`DCT_IDX_CTRL, 8'h00);
    wr(`DCT_IDX_MODE, 8'h97);
    wr(`DCT_IDX_TL0, 8'h00);
    wr(`DCT_IDX_TH0, 8'hF8);
    wr(`DCT_IDX_TL1, 8'hFE);
    wr(`DCT_IDX_TH1, 8'hFF);
    wr(`DCT_IDX_CTRL, 8'h10);
    n_baud = 0;
    gate(1, 4);
    rd_chk(`DCT_IDX_TL1, 8'h02, "timer one runs");
    chk_cnt(n_baud, 1, 1, "baud tick");
    chk_bit(oreq, 1'b0, "timer one no flag");
    rd_chk(`DCT_IDX_TH0, 8'hF8, "high byte held");
    pins(1'b0, 4'h3);
    rd_chk(`DCT_IDX_TL0, 8'h03, "low byte pins");
    wr(`DCT_IDX_MODE, 8'hB7);
    gate(1, 4);
    rd_chk(`DCT_IDX_TL1, 8'h02, "timer one stopped");
    wr(`DCT_IDX_CTRL, 8'h50);
    repeat (20) @(posedge aclk);
    chk_bit(oreq, 1'b1, "high byte overflow");
    chk_bit(zreq, 1'b0, "low byte quiet");
    ack_pulse(1);
    chk_bit(oreq, 1'b0, "vector clears");
    $display("split test done");
  endtask

  // Third timer byte ticks over a 48 cycle window.
  task automatic t_third;
    int t [4][4] = '{'{16, 0, 48, 48}, '{0, 0, 4, 4}, '{32, 1, 4, 48}, '{16, 1, 48, 4}};
    wr(`DCT_IDX_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`DCT_IDX_CLK, 8'(t[i][0]));
      split <= 1'(t[i][1]);
      repeat (4) @(posedge aclk);
      n_lo = 0;
      n_hi = 0;
      win <= 1'b1;
      repeat (48) @(posedge aclk);
      win <= 1'b0;
      @(posedge aclk);
      chk_cnt(n_lo, t[i][2], t[i][2], "third low ticks");
      chk_cnt(n_hi, t[i][3], t[i][3], "third high ticks");
    end
    // External clock divided by eight feeds both bytes when the external select is set.
    xsel <= 1'b1;
    ext_en <= 1'b1;
    wr(`DCT_IDX_CLK, 8'h00);
    repeat (4) @(posedge aclk);
    n_lo = 0;
    n_hi = 0;
    win <= 1'b1;
    repeat (48) @(posedge aclk);
    win <= 1'b0;
    @(posedge aclk);
    chk_cnt(n_lo, 2, 3, "third low external ticks");
    chk_cnt(n_hi, 2, 3, "third high external ticks");
    {xsel, ext_en, split} <= 3'h0;
    $display("third test done");
  endtask

  // External interrupt flags in edge and level mode, then inverted polarity.
  task automatic t_irq;
    wr(`DCT_IDX_CTRL, 8'h05);
    lvl <= 2'b11;
    repeat (6) @(posedge aclk);
    chk_bit(areq & breq, 1'b1, "edge flags set");
    lvl <= 2'b00;
    repeat (6) @(posedge aclk);
    chk_bit(areq & breq, 1'b1, "edge flags latched");
    ack_pulse(2);
    ack_pulse(3);
    chk_bit(areq | breq, 1'b0, "edge flags vectored");
    wr(`DCT_IDX_CTRL, 8'h00);
    lvl <= 2'b11;
    repeat (6) @(posedge aclk);
    ack_pulse(2);
    chk_bit(areq, 1'b1, "level flag kept");
    lvl <= 2'b00;
    repeat (6) @(posedge aclk);
    chk_bit(areq | breq, 1'b0, "level flags follow");
    wr(`DCT_IDX_IRQ, 8'h00);
    repeat (6) @(posedge aclk);
    chk_bit(areq & breq, 1'b1, "active low input");
    $display("irq test done");
  endtask

  // Final counts and verdict.
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, sel, ext_en} = '0;
    {split, win, xsel, awaddr, araddr, wdata, n, ack, lvl} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_modes;
    t_prescale;
    t_count;
    t_split;
    t_third;
    t_irq;
    end_of_test;
  end
endmodule
`default_nettype wire
